// file: hdl/psp_ctrl.sv
`timescale 1ns/1ns
module psp_ctrl (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] pair_reset_n,
  input  wire logic [3:0] pulse_in_pos,
  input  wire logic [3:0] pulse_in_neg,
  input  wire logic [3:0] oc_high_side,
  input  wire logic [3:0] oc_low_side,
  input  wire logic       gate_supply_low,
  input  wire logic       temp_above_warn,
  input  wire logic       temp_above_error,
  input  wire logic       prot_mode_strap_a,
  input  wire logic       prot_mode_strap_b,
  input  wire logic       output_mode_strap,
  output logic [3:0]      gate_high,
  output logic [3:0]      gate_low,
  output logic [1:0]      fault_status_n_o,
  output logic [1:0]      fault_status_n_oe,
  output logic            thermal_warning_n_o,
  output logic            thermal_warning_n_oe,
  output logic            strap_config_bad
);

  // Two-flop synchronisers for all pin inputs
  logic [1:0] rst_s1_q, rst_s2_q;
  logic [3:0] pos_s1_q, pos_s2_q;
  logic [3:0] neg_s1_q, neg_s2_q;
  logic [3:0] och_s1_q, och_s2_q;
  logic [3:0] ocl_s1_q, ocl_s2_q;
  logic [2:0] mon_s1_q, mon_s2_q;
  logic [2:0] strap_s1_q, strap_s2_q;

  // Pin synchronisers, first stage read only by second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_s1_q   <= 2'h0;
      rst_s2_q   <= 2'h0;
      pos_s1_q   <= 4'h0;
      pos_s2_q   <= 4'h0;
      neg_s1_q   <= 4'h0;
      neg_s2_q   <= 4'h0;
      och_s1_q   <= 4'h0;
      och_s2_q   <= 4'h0;
      ocl_s1_q   <= 4'h0;
      ocl_s2_q   <= 4'h0;
      mon_s1_q   <= 3'h0;
      mon_s2_q   <= 3'h0;
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      rst_s1_q   <= pair_reset_n;
      rst_s2_q   <= rst_s1_q;
      pos_s1_q   <= pulse_in_pos;
      pos_s2_q   <= pos_s1_q;
      neg_s1_q   <= pulse_in_neg;
      neg_s2_q   <= neg_s1_q;
      och_s1_q   <= oc_high_side;
      och_s2_q   <= och_s1_q;
      ocl_s1_q   <= oc_low_side;
      ocl_s2_q   <= ocl_s1_q;
      mon_s1_q   <= {gate_supply_low, temp_above_warn, temp_above_error};
      mon_s2_q   <= mon_s1_q;
      strap_s1_q <= {prot_mode_strap_a, prot_mode_strap_b,
                     output_mode_strap};
      strap_s2_q <= strap_s1_q;
    end
  end

  // Shared monitors: undervoltage and overtemperature error act on all bridges at once, warning only on its output
  logic uv_now;
  logic ot_warn_now;
  logic ot_err_now;
  assign uv_now      = mon_s2_q[2];
  assign ot_warn_now = mon_s2_q[1];
  assign ot_err_now  = mon_s2_q[0];

  // Straps captured while every pair sits in reset
  logic [1:0] prot_mode_q;
  logic       out_mode_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prot_mode_q <= psp_pkg::PROT_MODE_RST;
      out_mode_q  <= psp_pkg::OUT_MODE_RST;
    end else if (rst_s2_q == 2'h0) begin
      prot_mode_q <= strap_s2_q[2:1];
      out_mode_q  <= strap_s2_q[0];
    end
  end

  // Reserved strap codes flagged; device still latches on all errors
  logic strap_bad_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_bad_q <= 1'b0;
    end else begin
      strap_bad_q <= (prot_mode_q != psp_pkg::PROT_MODE_LATCHING) ||
                     (out_mode_q != psp_pkg::OUT_MODE_BRIDGE_TIED_LOAD);
    end
  end
  assign strap_config_bad = strap_bad_q;

  // Per-pair state: reset edge history, fault latch, enable
  logic [1:0] rst_prev_q;
  logic [1:0] fault_latch_q;
  logic [1:0] ot_latch_q;
  logic [1:0] pair_en_q;
  logic [3:0] bridge_en;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      logic oc_pair;
      logic err_now;

      // Overcurrent from either switch of both bridges in this pair
      assign oc_pair = |och_s2_q[2*p+1:2*p] |
                       |ocl_s2_q[2*p+1:2*p];
      assign err_now = oc_pair | uv_now | ot_err_now;

      // Reset edge history
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          rst_prev_q[p] <= 1'b0;
        end else begin
          rst_prev_q[p] <= rst_s2_q[p];
        end
      end

      // Error latch: falling reset clears, error set wins while high
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          fault_latch_q[p] <= psp_pkg::FAULT_LATCH_RST;
          ot_latch_q[p]    <= psp_pkg::FAULT_LATCH_RST;
        end else if (rst_s2_q[p] && err_now) begin
          fault_latch_q[p] <= 1'b1;
          ot_latch_q[p]    <= ot_latch_q[p] | ot_err_now;
        end else if (rst_prev_q[p] && !rst_s2_q[p]) begin
          fault_latch_q[p] <= 1'b0;
          ot_latch_q[p]    <= 1'b0;
        end
      end

      // Enable only with reset high and no error latched or present
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pair_en_q[p] <= 1'b0;
        end else begin
          pair_en_q[p] <= rst_s2_q[p] && !err_now &&
                          !fault_latch_q[p];
        end
      end

      assign bridge_en[2*p]   = pair_en_q[p];
      assign bridge_en[2*p+1] = pair_en_q[p];

      // Fault output: pulled low only in protection with reset high
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          fault_status_n_oe[p] <= 1'b0;
        end else begin
          fault_status_n_oe[p] <= rst_s2_q[p] &&
            (fault_latch_q[p] || err_now);
        end
      end
      assign fault_status_n_o[p] = 1'b0;
    end
  endgenerate

  // Thermal warning common to the device, also low on latched overtemp
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thermal_warning_n_oe <= 1'b0;
    end else begin
      thermal_warning_n_oe <= ot_warn_now || ot_err_now ||
                              (|ot_latch_q);
    end
  end
  assign thermal_warning_n_o = 1'b0;

  // Half-bridge drivers, one per bridge
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bridge
      psp_half_bridge u_hb (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .enable    (bridge_en[b]),
        .pulse_pos (pos_s2_q[b]),
        .pulse_neg (neg_s2_q[b]),
        .gate_high (gate_high[b]),
        .gate_low  (gate_low[b])
      );
    end
  endgenerate

endmodule

// file: hdl/psp_half_bridge.sv
`timescale 1ns/1ns
module psp_half_bridge (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic pulse_pos,
  input  wire logic pulse_neg,
  output logic      gate_high,
  output logic      gate_low
);

  psp_pkg::psp_hb_state_t state_q;
  psp_pkg::psp_hb_state_t state_d;
  logic                   first_low_seen_q;
  logic [psp_pkg::DEAD_CNT_W-1:0] dead_q;
  logic                   want_high;
  logic                   want_low;

  // Requested conduction, both high or both low means neither switch on
  assign want_high = pulse_pos & ~pulse_neg;
  assign want_low  = ~pulse_pos & pulse_neg;

  // Next state: high side only once a low-side pulse charged bootstrap
  always_comb begin
    state_d = state_q;
    if (!enable) begin
      state_d = psp_pkg::PSP_HB_HIZ;
    end else if (dead_q != '0) begin
      state_d = psp_pkg::PSP_HB_HIZ;
    end else if (want_low) begin
      state_d = psp_pkg::PSP_HB_LOW;
    end else if (want_high && first_low_seen_q) begin
      state_d = psp_pkg::PSP_HB_HIGH;
    end else begin
      state_d = psp_pkg::PSP_HB_HIZ;
    end
    // Never swap switches directly, pass through high-impedance first
    if (state_q != psp_pkg::PSP_HB_HIZ && state_d != state_q) begin
      state_d = psp_pkg::PSP_HB_HIZ;
    end
  end

  // Drive state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= psp_pkg::PSP_HB_HIZ;
    end else begin
      state_q <= state_d;
    end
  end

  // Dead time inserted when leaving a conducting state
  always_ff @(posedge clk) begin
    if (sys_rst || !enable) begin
      dead_q <= '0;
    end else if (state_q != psp_pkg::PSP_HB_HIZ && state_d != state_q) begin
      dead_q <= psp_pkg::DEAD_CNT_W'(psp_pkg::DEAD_TIME_CYCLES);
    end else if (dead_q != '0) begin
      dead_q <= dead_q - 1'b1;
    end
  end

  // Bootstrap charge flag, cleared whenever the stage is disabled
  always_ff @(posedge clk) begin
    if (sys_rst || !enable) begin
      first_low_seen_q <= 1'b0;
    end else if (state_q == psp_pkg::PSP_HB_LOW) begin
      first_low_seen_q <= 1'b1;
    end
  end

  // Gate outputs straight from the state flops
  assign gate_high = (state_q == psp_pkg::PSP_HB_HIGH);
  assign gate_low  = (state_q == psp_pkg::PSP_HB_LOW);

endmodule

// file: hdl/psp_pkg.sv
package psp_pkg;

  // Number of half-bridges per reset pair and number of pairs
  localparam int unsigned BRIDGES_PER_PAIR = 2;
  localparam int unsigned PAIR_COUNT       = 2;

  // Clock rate used to turn times into cycle counts
  localparam int unsigned CLK_FREQ_MHZ = 125;

  // Reset input debounce time in ns, unused: pair resets pass only the two-flop synchroniser
  localparam int unsigned RESET_FILTER_NS     = 80;
  localparam int unsigned RESET_FILTER_CYCLES =
    (RESET_FILTER_NS * CLK_FREQ_MHZ + 999) / 1000;

  // Gate dead time between high-side and low-side conduction, in ns
  localparam int unsigned DEAD_TIME_NS     = 24;
  localparam int unsigned DEAD_TIME_CYCLES =
    (DEAD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned DEAD_CNT_W = 4;

  // Protection mode strap codes {strap_a, strap_b}
  localparam logic [1:0] PROT_MODE_LATCHING = 2'h1;

  // Output mode strap code for bridge-tied load
  localparam logic OUT_MODE_BRIDGE_TIED_LOAD = 1'b0;

  // Reset values
  localparam logic       FAULT_LATCH_RST  = 1'b0;
  localparam logic [1:0] PROT_MODE_RST    = PROT_MODE_LATCHING;
  localparam logic       OUT_MODE_RST     = OUT_MODE_BRIDGE_TIED_LOAD;

  // Half-bridge drive state
  typedef enum logic [1:0] {
    PSP_HB_HIZ  = 2'b00,
    PSP_HB_LOW  = 2'b01,
    PSP_HB_HIGH = 2'b11
  } psp_hb_state_t;

endpackage

// file: testbench/psp_ctrl_sva.sv
`timescale 1ns/1ns
module psp_ctrl_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [1:0] pair_reset_n,
  input wire logic [3:0] oc_high_side,
  input wire logic [3:0] oc_low_side,
  input wire logic       temp_above_warn,
  input wire logic       temp_above_error,
  input wire logic [3:0] gate_high,
  input wire logic [3:0] gate_low,
  input wire logic [1:0] fault_status_n_o,
  input wire logic [1:0] fault_status_n_oe,
  input wire logic       thermal_warning_n_o,
  input wire logic       thermal_warning_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] rq_q;
  logic       seen_low_q;
  // Forgets low-side history once pair 0 sat in reset long enough
  always_ff @(posedge clk) begin
    rq_q <= {rq_q[2:0], pair_reset_n[0]};
    if (sys_rst || (rq_q == 4'h0 && !pair_reset_n[0])) begin
      seen_low_q <= 1'b0;
    end else if (gate_low[0]) begin
      seen_low_q <= 1'b1;
    end
  end
  sequence s_oc0;
    ((|{oc_high_side[1:0], oc_low_side[1:0]}) && pair_reset_n[0])[*3];
  endsequence
  sequence s_rst0_low;
    !pair_reset_n[0] [*6];
  endsequence
  reset_hiz_a: assert property (s_rst0_low |->
    (gate_high[1:0] | gate_low[1:0]) == 2'h0) else $error("gates on in reset");
  fault_rel_a: assert property (!pair_reset_n[1] [*5] |->
    !fault_status_n_oe[1]) else $error("fault low in reset");
  oc_fault_a: assert property (s_oc0 |=> fault_status_n_oe[0])
    else $error("overcurrent not flagged");
  err_hiz_a: assert property (fault_status_n_oe[0] |=>
    (gate_high[1:0] | gate_low[1:0]) == 2'h0) else $error("gates on in fault");
  warn_low_a: assert property (temp_above_warn [*3] |=>
    thermal_warning_n_oe) else $error("warning missing");
  ote_both_a: assert property ((temp_above_error && pair_reset_n[0])[*3]
    |=> thermal_warning_n_oe && fault_status_n_oe[0]) else $error("ote");
  od_drive_a: assert property (fault_status_n_o == 2'h0
    && !thermal_warning_n_o) else $error("open drain drives high");
  hs_after_ls_a: assert property (gate_high[0] |-> seen_low_q)
    else $error("high side before low side");
endmodule
bind psp_ctrl psp_ctrl_chk i_chk (.*);

// file: testbench/psp_pulse_model.sv
`timescale 1ns/1ns
module psp_pulse_model #(
  parameter int HALF = 167
) (
  input  wire logic       clk,
  input  wire logic       run,
  output logic      [3:0] pos,
  output logic      [3:0] neg
);
  logic [8:0] cnt_q;
  logic       ph_q;
  // Square wave of 334 cycles, 374 kHz, low phase first
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt_q <= 9'h0;
      ph_q  <= 1'b0;
    end else if (cnt_q == 9'(HALF - 1)) begin
      cnt_q <= 9'h0;
      ph_q  <= !ph_q;
    end else begin
      cnt_q <= cnt_q + 9'h1;
    end
  end
  // Stopped outputs fall to the pull-down level
  assign pos = run ? {4{ph_q}} : 4'h0;
  assign neg = run ? {4{!ph_q}} : 4'h0;
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       clk, sys_rst, run, uv, tw, te, sa, sb, om, bad, to, toe;
  logic [1:0] rst_n, fo, foe;
  logic [3:0] pos, neg, och, ocl, gh, gl, gh_acc, gl_acc;
  logic [3:0] gm [4] = '{4'hC, 4'h3, 4'h0, 4'h0};
  logic [1:0] fm [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  int         n_errors, n_compared, cyc;
  psp_pulse_model i_mod (.clk(clk), .run(run), .pos(pos), .neg(neg));
  psp_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .pair_reset_n(rst_n),
    .pulse_in_pos(pos), .pulse_in_neg(neg), .oc_high_side(och),
    .oc_low_side(ocl), .gate_supply_low(uv), .temp_above_warn(tw),
    .temp_above_error(te), .prot_mode_strap_a(sa), .prot_mode_strap_b(sb),
    .output_mode_strap(om), .gate_high(gh), .gate_low(gl),
    .fault_status_n_o(fo), .fault_status_n_oe(foe),
    .thermal_warning_n_o(to), .thermal_warning_n_oe(toe),
    .strap_config_bad(bad));
  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Collects which switches turned on over n cycles
  task automatic watch(int n);
    gh_acc = 4'h0;
    gl_acc = 4'h0;
    repeat (n) begin
      step(1);
      gh_acc |= gh;
      gl_acc |= gl;
    end
  endtask
  task results;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    {sys_rst, rst_n, run, och, ocl, uv, tw, te, sa, sb, om} = 18'h20002;
    step(3);
    sys_rst = 1'b0;
    for (int c = 0; c < 4; c++) begin
      {sa, sb} = c[1:0];
      step(8);
      chk("strap", {3'h0, bad}, {3'h0, c != 1});
    end
    {sa, sb} = 2'h1;
    om = 1'b1;
    step(8);
    chk("out mode", {3'h0, bad}, 4'h1);
    om = 1'b0;
    run = 1'b1;
    step(8);
    chk("mute", gh | gl, 4'h0);
    rst_n = 2'h3;
    watch(400);
    chk("high", gh_acc, 4'hF);
    chk("low", gl_acc, 4'hF);
    for (int k = 0; k < 4; k++) begin
      och = (k == 0) ? 4'h2 : 4'h0;
      ocl = (k == 1) ? 4'h8 : 4'h0;
      {uv, te, tw} = {k == 2, k == 3, k == 3};
      step(6);
      chk("fault", {2'h0, foe}, {2'h0, fm[k]});
      chk("warn", {3'h0, toe}, {3'h0, k == 3});
      {och, ocl, uv, te, tw} = 11'h0;
      watch(400);
      chk("stop", gh_acc | gl_acc, gm[k]);
      chk("latch", {2'h0, foe}, {2'h0, fm[k]});
      rst_n = 2'h0;
      step(8);
      chk("fault rel", {2'h0, foe}, 4'h0);
      rst_n = 2'h3;
      watch(400);
      chk("resume", gh_acc | gl_acc, 4'hF);
      chk("clear", {1'h0, foe, toe}, 4'h0);
    end
    tw = 1'b1;
    step(6);
    chk("warn only", {1'h0, foe, toe}, 4'h1);
    tw = 1'b0;
    step(6);
    chk("warn gone", {3'h0, toe}, 4'h0);
    rst_n = 2'h0;
    step(8);
    run = 1'b0;
    step(4);
    chk("down", gh | gl, 4'h0);
    chk("open drain", {2'h0, fo[0], to}, 4'h0);
    chk("open drain b", {3'h0, fo[1]}, 4'h0);
    results();
  end
endmodule
